//--- hdl/twm_master_rx.sv
// two-wire master receiver: register port, command sequencer and bit engine
//
// Functional notes
// - start issued only when bus is free
// - after start: flag set, status 0x08
// - address direction bit selects receive or transmit
// - after read address: flag, status 0x38/0x40/0x48
// - received byte readable while flag set
// - stop request sends stop, self clears
// - start request gives repeated start, status 0x10
// - write address after 0x10 enters transmit mode
// - 0x38 clear without start releases bus
// - 0x38 clear with start waits free bus
// - 0x40 clear receives byte, ack per enable
// - 0x48 clear: restart, stop, or stop+start
// - 0x50 clear receives next byte
// - 0x58 clear: restart, stop, or stop+start
// - start and stop: stop then start
// - flag cleared by writing one only; here the enable bit must be written one too
// - data write with flag low sets collision
//
// Our own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
module twm_master_rx #(
    parameter int HALF_CYC = twm_pkg::SCL_HALF_CYC,
    parameter int FREE_CYC = twm_pkg::BUS_FREE_CYC
) (
    // clock and reset
    input  wire logic       core_clk_i,
    input  wire logic       reset_i,
    // register port
    input  wire logic [1:0] reg_addr_i,
    input  wire logic [7:0] reg_wdata_i,
    input  wire logic       reg_wr_i,
    input  wire logic       reg_rd_i,
    output logic      [7:0] reg_rdata_o,
    // two-wire pins
    input  wire logic       scl_i,
    output logic            scl_o,
    output logic            scl_oe_o,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe_o,
    // mode
    output logic            master_tx_mode_o
);

    // *****************************
    // state
    // *****************************
    typedef enum logic [6:0] {
        TWM_IDLE  = 7'b0000001,
        TWM_WFREE = 7'b0000010,
        TWM_START = 7'b0000100,
        TWM_BITS  = 7'b0001000,
        TWM_STOP  = 7'b0010000,
        TWM_HOLD  = 7'b0100000,
        TWM_RSTRT = 7'b1000000
    } twm_state_t;

    twm_pkg::twm_reg_req_t     req;
    twm_pkg::twm_pin_drive_t   drv_q;
    twm_pkg::twm_pin_drive_t   drv_d;
    twm_state_t  state_q, state_d;
    logic [7:0]  ctl_q, ctl_d;
    logic [4:0]  stat_q, stat_d;
    logic [7:0]  data_q, data_d;
    logic [7:0]  rdata_q, rdata_d;
    logic [3:0]  bit_q, bit_d;
    logic [1:0]  phase_q, phase_d;
    logic [7:0]  tmr_q, tmr_d;
    logic        is_addr_q, is_addr_d;
    logic        rx_q, rx_d;
    logic        txm_q, txm_d;
    logic        then_start_q, then_start_d;
    logic [1:0]  pins_s;
    logic        busy, free, scl_rise;
    logic        ctl_wr, flag_clr, tick;

    assign req = '{addr: reg_addr_i, wdata: reg_wdata_i, wr: reg_wr_i, rd: reg_rd_i};

    twm_sync #(
        .WIDTH (2)
    ) u_sync (
        .core_clk_i (core_clk_i),
        .reset_i    (reset_i),
        .async_i    ({scl_i, sda_i}),
        .sync_o     (pins_s)
    );

    twm_bus_watch #(
        .FREE_CYC (FREE_CYC)
    ) u_watch (
        .core_clk_i (core_clk_i),
        .reset_i    (reset_i),
        .scl_i      (pins_s[1]),
        .sda_i      (pins_s[0]),
        .busy_o     (busy),
        .free_o     (free),
        .scl_rise_o (scl_rise)
    );

    assign ctl_wr   = req.wr && req.addr == twm_pkg::ADDR_CONTROL;
    // writing zero to the flag has no effect
    assign flag_clr = ctl_wr && req.wdata[twm_pkg::CTL_DONE_BIT]
                      && req.wdata[twm_pkg::CTL_EN_BIT];
    assign tick     = (tmr_q == 8'h00);

    // *****************************
    // next state
    // *****************************
    always_comb
    begin
        state_d      = state_q;
        ctl_d        = ctl_q;
        stat_d       = stat_q;
        data_d       = data_q;
        bit_d        = bit_q;
        phase_d      = phase_q;
        is_addr_d    = is_addr_q;
        rx_d         = rx_q;
        txm_d        = txm_q;
        then_start_d = then_start_q;
        drv_d        = drv_q;
        tmr_d        = tick ? 8'(HALF_CYC - 1) : tmr_q - 8'h01;
        rdata_d      = 8'h00;

        // register writes; flag bit kept, only hardware sets it
        if (ctl_wr)
        begin
            ctl_d = {ctl_q[7], req.wdata[6:4], ctl_q[3], req.wdata[2], 1'b0,
                     req.wdata[0]};
            if (flag_clr)
            begin
                ctl_d[twm_pkg::CTL_DONE_BIT] = 1'b0;
                ctl_d[twm_pkg::CTL_WCOL_BIT] = 1'b0;
            end
        end
        if (req.wr && req.addr == twm_pkg::ADDR_DATA)
        begin
            if (ctl_q[twm_pkg::CTL_DONE_BIT])
                data_d = req.wdata;
            else
                ctl_d[twm_pkg::CTL_WCOL_BIT] = 1'b1;
        end
        if (req.rd)
        begin
            case (req.addr)
                twm_pkg::ADDR_CONTROL: rdata_d = ctl_q;
                twm_pkg::ADDR_STATUS:  rdata_d = {stat_q, 3'b000};
                twm_pkg::ADDR_DATA:    rdata_d = data_q;
                default:               rdata_d = 8'h00;
            endcase
        end

        case (state_q)
            TWM_IDLE:
            begin
                drv_d = '{scl_oe: 1'b0, sda_oe: 1'b0};
                if (flag_clr && req.wdata[twm_pkg::CTL_START_BIT])
                    state_d = TWM_WFREE;
            end
            TWM_WFREE:
            begin
                if (free && !busy)
                begin
                    state_d = TWM_START;
                    tmr_d   = 8'(HALF_CYC - 1);
                    phase_d = 2'd0;
                end
            end
            TWM_START, TWM_RSTRT:
            begin
                // release both, then pull data low with clock high, then clock low
                if (tick)
                begin
                    phase_d = phase_q + 2'd1;
                    case (phase_q)
                        2'd0: drv_d = '{scl_oe: 1'b0, sda_oe: 1'b0};
                        2'd1: drv_d = '{scl_oe: 1'b0, sda_oe: 1'b1};
                        default:
                        begin
                            drv_d  = '{scl_oe: 1'b1, sda_oe: 1'b1};
                            ctl_d[twm_pkg::CTL_DONE_BIT] = 1'b1;
                            stat_d = (state_q == TWM_START) ? twm_pkg::ST_START[7:3]
                                     : twm_pkg::ST_RSTART[7:3];
                            is_addr_d = 1'b1;
                            state_d   = TWM_HOLD;
                        end
                    endcase
                end
            end
            TWM_HOLD:
            begin
                drv_d.scl_oe = 1'b1;
                // data let go only once the clock is already low, never beside its edge
                drv_d.sda_oe = 1'b0;
                if (flag_clr)
                begin
                    phase_d = 2'd0;
                    bit_d   = 4'd0;
                    if (req.wdata[twm_pkg::CTL_STOP_BIT])
                    begin
                        then_start_d = req.wdata[twm_pkg::CTL_START_BIT];
                        state_d      = TWM_STOP;
                    end
                    else if (stat_q == twm_pkg::ST_ARB_LOST[7:3])
                        // release if no start is pending; with one, wait for a free bus with the clock still held low
                        state_d = req.wdata[twm_pkg::CTL_START_BIT] ? TWM_WFREE
                                  : TWM_IDLE;
                    else if (req.wdata[twm_pkg::CTL_START_BIT])
                        state_d = TWM_RSTRT;
                    else if (stat_q == twm_pkg::ST_RADDR_NACK[7:3]
                             || stat_q == twm_pkg::ST_DATA_NACK[7:3])
                        state_d = TWM_HOLD;
                    else
                    begin
                        // address after a start, else a data byte
                        rx_d    = !is_addr_q;
                        if (is_addr_q)
                            txm_d = !data_q[0];
                        state_d = TWM_BITS;
                    end
                end
            end
            TWM_BITS:
            begin
                // phase 0: set data with clock low; 1: release clock; 2: sample
                if (tick)
                begin
                    case (phase_q)
                        2'd0:
                        begin
                            if (bit_q == 4'd8)
                                drv_d.sda_oe = rx_q && ctl_q[twm_pkg::CTL_ACKEN_BIT];
                            else
                                drv_d.sda_oe = !rx_q && !data_q[7];
                            phase_d = 2'd1;
                        end
                        2'd1:
                        begin
                            // data settled a tick before the clock rises
                            drv_d.scl_oe = 1'b0;
                            // wait for clock to rise; slave may stretch
                            if (pins_s[1])
                                phase_d = 2'd2;
                        end
                        default:
                        begin
                            drv_d.scl_oe = 1'b1;
                            phase_d      = 2'd0;
                            bit_d        = bit_q + 4'd1;
                            if (bit_q != 4'd8)
                                data_d = {data_q[6:0], pins_s[0]};
                            else
                            begin
                                ctl_d[twm_pkg::CTL_DONE_BIT] = 1'b1;
                                is_addr_d = 1'b0;
                                state_d   = TWM_HOLD;
                                if (is_addr_q && txm_q)
                                    stat_d = pins_s[0] ? twm_pkg::ST_WADDR_NACK[7:3]
                                             : twm_pkg::ST_WADDR_ACK[7:3];
                                else if (is_addr_q)
                                    stat_d = pins_s[0] ? twm_pkg::ST_RADDR_NACK[7:3]
                                             : twm_pkg::ST_RADDR_ACK[7:3];
                                else
                                    stat_d = ctl_q[twm_pkg::CTL_ACKEN_BIT]
                                             ? twm_pkg::ST_DATA_ACK[7:3]
                                             : twm_pkg::ST_DATA_NACK[7:3];
                            end
                        end
                    endcase
                    // arbitration: released data line seen low
                    if (phase_q == 2'd2 && !drv_q.sda_oe && !pins_s[0] && bit_q != 4'd8
                        && !rx_q)
                    begin
                        drv_d   = '{scl_oe: 1'b0, sda_oe: 1'b0};
                        ctl_d[twm_pkg::CTL_DONE_BIT] = 1'b1;
                        stat_d  = twm_pkg::ST_ARB_LOST[7:3];
                        state_d = TWM_HOLD;
                    end
                end
            end
            TWM_STOP:
            begin
                if (tick)
                begin
                    phase_d = phase_q + 2'd1;
                    case (phase_q)
                        2'd0: drv_d = '{scl_oe: 1'b1, sda_oe: 1'b1};
                        2'd1: drv_d = '{scl_oe: 1'b0, sda_oe: 1'b1};
                        default:
                        begin
                            drv_d = '{scl_oe: 1'b0, sda_oe: 1'b0};
                            ctl_d[twm_pkg::CTL_STOP_BIT] = 1'b0;
                            stat_d  = twm_pkg::ST_IDLE[7:3];
                            state_d = then_start_q ? TWM_WFREE : TWM_IDLE;
                            then_start_d = 1'b0;
                        end
                    endcase
                end
            end
            default: state_d = TWM_IDLE;
        endcase

        // disabled interface releases the bus
        if (!ctl_d[twm_pkg::CTL_EN_BIT])
        begin
            state_d = TWM_IDLE;
            drv_d   = '{scl_oe: 1'b0, sda_oe: 1'b0};
        end
    end

    // *****************************
    // registers
    // *****************************
    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
        begin
            state_q      <= TWM_IDLE;
            ctl_q        <= twm_pkg::CONTROL_RESET;
            stat_q       <= twm_pkg::STATUS_RESET;
            data_q       <= twm_pkg::DATA_RESET;
            rdata_q      <= 8'h00;
            bit_q        <= 4'd0;
            phase_q      <= 2'd0;
            tmr_q        <= 8'h00;
            is_addr_q    <= 1'b0;
            rx_q         <= 1'b0;
            txm_q        <= 1'b0;
            then_start_q <= 1'b0;
            drv_q        <= '{scl_oe: 1'b0, sda_oe: 1'b0};
        end
        else
        begin
            state_q      <= state_d;
            ctl_q        <= ctl_d;
            stat_q       <= stat_d;
            data_q       <= data_d;
            rdata_q      <= rdata_d;
            bit_q        <= bit_d;
            phase_q      <= phase_d;
            tmr_q        <= tmr_d;
            is_addr_q    <= is_addr_d;
            rx_q         <= rx_d;
            txm_q        <= txm_d;
            then_start_q <= then_start_d;
            drv_q        <= drv_d;
        end
    end

    // *****************************
    // outputs
    // *****************************
    // open drain: outputs always low, enables from flops
    assign reg_rdata_o      = rdata_q;
    assign scl_o            = 1'b0;
    assign sda_o            = 1'b0;
    assign scl_oe_o         = drv_q.scl_oe;
    assign sda_oe_o         = drv_q.sda_oe;
    assign master_tx_mode_o = txm_q;

endmodule

//--- hdl/twm_pkg.sv
// package: register map, status codes, timing and carrier types for the two-wire master receiver
package twm_pkg;

    // *****************************
    // register offsets
    // *****************************
    localparam logic [1:0] ADDR_CONTROL = 2'h0;
    localparam logic [1:0] ADDR_STATUS  = 2'h1;
    localparam logic [1:0] ADDR_DATA    = 2'h2;

    // *****************************
    // control field positions
    // *****************************
    localparam int CTL_DONE_BIT  = 7;
    localparam int CTL_ACKEN_BIT = 6;
    localparam int CTL_START_BIT = 5;
    localparam int CTL_STOP_BIT  = 4;
    localparam int CTL_WCOL_BIT  = 3;
    localparam int CTL_EN_BIT    = 2;
    localparam int CTL_IRQEN_BIT = 0;

    // *****************************
    // reset values
    // *****************************
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] DATA_RESET    = 8'hff;
    localparam logic [4:0] STATUS_RESET  = 5'h1f;

    // *****************************
    // status codes, upper five bits of the status register
    // *****************************
    localparam logic [7:0] ST_START      = 8'h08;
    localparam logic [7:0] ST_RSTART     = 8'h10;
    localparam logic [7:0] ST_WADDR_ACK  = 8'h18;
    localparam logic [7:0] ST_WADDR_NACK = 8'h20;
    localparam logic [7:0] ST_ARB_LOST   = 8'h38;
    localparam logic [7:0] ST_RADDR_ACK  = 8'h40;
    localparam logic [7:0] ST_RADDR_NACK = 8'h48;
    localparam logic [7:0] ST_DATA_ACK   = 8'h50;
    localparam logic [7:0] ST_DATA_NACK  = 8'h58;
    localparam logic [7:0] ST_IDLE       = 8'hf8;

    // *****************************
    // bus timing
    // *****************************
    localparam int CLK_HZ        = 20000000;
    localparam int SCL_HALF_NS   = 5000;
    localparam int SCL_HALF_CYC  = (SCL_HALF_NS * (CLK_HZ / 1000000)) / 1000;
    localparam int BUS_FREE_NS   = 5000;
    localparam int BUS_FREE_CYC  = (BUS_FREE_NS * (CLK_HZ / 1000000) + 999) / 1000;

    // *****************************
    // carrier types
    // *****************************
    typedef struct packed {
        logic [1:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } twm_reg_req_t;

    typedef struct packed {
        logic scl_oe;
        logic sda_oe;
    } twm_pin_drive_t;

endpackage

//--- hdl/twm_sync.sv
// two-flop synchroniser for the serial clock and data pins
`timescale 1ns/1ps
module twm_sync #(
    parameter int WIDTH = 2
) (
    // clock and reset
    input  wire logic             core_clk_i,
    input  wire logic             reset_i,
    // asynchronous levels in, synchronous levels out
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] sync_d;

    // idle bus lines are high, so reset to high
    always_comb
    begin
        meta_d = async_i;
        sync_d = meta_q;
    end

    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
        begin
            meta_q <= '1;
            sync_q <= '1;
        end
        else
        begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_o = sync_q;

endmodule

//--- hdl/twm_bus_watch.sv
// bus watcher: start and stop detection, busy tracking and free-time counting
`timescale 1ns/1ps
module twm_bus_watch #(
    parameter int FREE_CYC = twm_pkg::BUS_FREE_CYC
) (
    // clock and reset
    input  wire logic core_clk_i,
    input  wire logic reset_i,
    // synchronised line levels
    input  wire logic scl_i,
    input  wire logic sda_i,
    // bus state
    output logic      busy_o,
    output logic      free_o,
    output logic      scl_rise_o
);

    logic       scl_prev_q;
    logic       sda_prev_q;
    logic       busy_q;
    logic [7:0] free_cnt_q;
    logic       scl_prev_d;
    logic       sda_prev_d;
    logic       busy_d;
    logic [7:0] free_cnt_d;

    always_comb
    begin
        scl_prev_d = scl_i;
        sda_prev_d = sda_i;
        busy_d     = busy_q;
        // start: data falls while clock high; stop: data rises while clock high
        if (scl_i && scl_prev_q && sda_prev_q && !sda_i)
            busy_d = 1'b1;
        else if (scl_i && scl_prev_q && !sda_prev_q && sda_i)
            busy_d = 1'b0;
        if (busy_d || !scl_i || !sda_i)
            free_cnt_d = 8'h00;
        else if (free_cnt_q != 8'(FREE_CYC))
            free_cnt_d = free_cnt_q + 8'h01;
        else
            free_cnt_d = free_cnt_q;
    end

    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
        begin
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
            busy_q     <= 1'b0;
            free_cnt_q <= 8'h00;
        end
        else
        begin
            scl_prev_q <= scl_prev_d;
            sda_prev_q <= sda_prev_d;
            busy_q     <= busy_d;
            free_cnt_q <= free_cnt_d;
        end
    end

    assign busy_o     = busy_q;
    assign free_o     = (free_cnt_q == 8'(FREE_CYC));
    assign scl_rise_o = scl_i && !scl_prev_q;

endmodule

//--- test/twm_rx_checker.sv
// checker: port-level assertions for the two-wire master receiver
`timescale 1ns/1ps
module twm_rx_checker #(
    parameter int HALF_CYC = 4
) (
    // clock, reset and register port
    input wire logic       core_clk_i,
    input wire logic       reset_i,
    input wire logic [1:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic       reg_wr_i,
    input wire logic       reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    // bus pins and mode
    input wire logic       scl_i,
    input wire logic       scl_o,
    input wire logic       scl_oe_o,
    input wire logic       sda_i,
    input wire logic       sda_o,
    input wire logic       sda_oe_o,
    input wire logic       master_tx_mode_o
);
    // *****
    // released-clock length, saturating so it never wraps
    // *****
    int hi_q;
    int hi_d;
    always_comb
    begin
        hi_d = scl_oe_o ? 0 : ((hi_q < 1000) ? hi_q + 1 : hi_q);
    end
    always_ff @(posedge core_clk_i)
    begin
        hi_q <= reset_i ? 0 : hi_d;
    end
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (reset_i);
    sequence ctl_rd;
        reg_rd_i && reg_addr_i == twm_pkg::ADDR_CONTROL;
    endsequence
    sequence sts_rd;
        reg_rd_i && reg_addr_i == twm_pkg::ADDR_STATUS;
    endsequence
    rdata_idle_a: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00)
        else $error("read data not zero outside answer cycle");
    unmapped_read_a: assert property (reg_rd_i && reg_addr_i == 2'h3 |=> reg_rdata_o == 8'h00)
        else $error("unmapped read not zero");
    status_mask_a: assert property (sts_rd |=> reg_rdata_o[2:0] == 3'h0)
        else $error("status low bits not zero");
    status_code_a: assert property (sts_rd |=> reg_rdata_o inside
        {8'h08, 8'h10, 8'h18, 8'h20, 8'h38, 8'h40, 8'h48, 8'h50, 8'h58, 8'hf8})
        else $error("status code outside the defined set");
    flag_hold_a: assert property (ctl_rd ##1 reg_rdata_o[7] |-> scl_oe_o)
        else $error("clock not held low while flag set");
    reset_idle_a: assert property ($fell(reset_i) |-> !scl_oe_o && !sda_oe_o)
        else $error("pins driven after reset");
    pins_low_a: assert property (!scl_o && !sda_o)
        else $error("pin output level not low");
    scl_high_a: assert property ($rose(scl_oe_o) |-> hi_q >= HALF_CYC)
        else $error("clock high phase too short");
endmodule

bind twm_master_rx twm_rx_checker #(.HALF_CYC(HALF_CYC)) u_twm_rx_checker (
    .core_clk_i(core_clk_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .scl_i(scl_i), .scl_o(scl_o), .scl_oe_o(scl_oe_o),
    .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .master_tx_mode_o(master_tx_mode_o));

//--- test/twm_slave_model.sv
// partner: behavioural slave transmitter on the two-wire bus
`timescale 1ns/1ps
module twm_slave_model #(
    parameter logic [6:0] DEV_ADDR = 7'h2a
) (
    // wired-and bus lines
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output logic            scl_oe_o = 1'b0,
    output logic            sda_oe_o = 1'b0,
    // byte source and pacing
    input  wire logic [7:0] base_i,
    input  wire logic       stretch_i
);
    logic [7:0] sh_q = 8'h00;
    logic [7:0] tx_q = 8'h00;
    logic       first_q = 1'b1;
    logic       rd_q = 1'b0;
    int         n_q = 10;
    int         k_q = 0;
    always @(negedge sda_i)
        if (scl_i)
        begin
            n_q = 0;
            k_q = 0;
            first_q = 1'b1;
            rd_q = 1'b0;
        end
    always @(posedge sda_i)
        if (scl_i)
        begin
            rd_q = 1'b0;
            n_q = 10;
        end
    always @(posedge scl_i)
    begin
        if (n_q < 8)
            sh_q = {sh_q[6:0], sda_i};
        if (n_q == 8 && !first_q && sda_i)
            rd_q = 1'b0;
        n_q++;
    end
    // only read addresses are acknowledged; writes see a nack
    always @(negedge scl_i)
    begin
        sda_oe_o = 1'b0;
        if (n_q == 8 && first_q && sh_q == {DEV_ADDR, 1'b1})
        begin
            sda_oe_o = 1'b1;
            rd_q = 1'b1;
        end
        else if (n_q == 9)
        begin
            n_q = 0;
            first_q = 1'b0;
            if (rd_q)
            begin
                tx_q = base_i + 8'(k_q);
                k_q++;
                sda_oe_o = !tx_q[7];
                if (stretch_i)
                begin
                    scl_oe_o = 1'b1;
                    #1000 scl_oe_o = 1'b0;
                end
            end
        end
        else if (rd_q && !first_q && n_q > 0 && n_q < 8)
            sda_oe_o = !tx_q[7 - n_q];
    end
endmodule

//--- test/tb_top.sv
// testbench: random and corner-case receive traffic against the slave model
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin mismatches++; \
    $display("ERROR t=%0t got %h exp %h", $time, g, e); end end
module tb_top;
    localparam logic [6:0] DEV = 7'h2a;
    localparam logic [1:0] CTL = twm_pkg::ADDR_CONTROL;
    localparam logic [1:0] STS = twm_pkg::ADDR_STATUS;
    localparam logic [1:0] DAT = twm_pkg::ADDR_DATA;
    logic       core_clk_i = 1'b0;
    logic       reset_i = 1'b1;
    logic [1:0] addr = 2'h0;
    logic [7:0] wdata = 8'h00;
    logic       wr = 1'b0;
    logic       rd = 1'b0;
    logic [7:0] rdata;
    logic       scl, sda, m_scl, m_sda, s_scl, s_sda, tx_mode;
    logic [7:0] base = 8'h00;
    logic       stretch = 1'b0;
    logic [7:0] v;
    int         mismatches = 0;
    int         tests_run = 0;
    int         nb;
    assign scl = !(m_scl || s_scl);
    assign sda = !(m_sda || s_sda);
    twm_master_rx #(.HALF_CYC(4), .FREE_CYC(4)) u_twm_master_rx (
        .core_clk_i(core_clk_i), .reset_i(reset_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .scl_i(scl), .scl_o(),
        .scl_oe_o(m_scl), .sda_i(sda), .sda_o(), .sda_oe_o(m_sda), .master_tx_mode_o(tx_mode));
    twm_slave_model #(.DEV_ADDR(DEV)) u_twm_slave_model (.scl_i(scl), .sda_i(sda),
        .scl_oe_o(s_scl), .sda_oe_o(s_sda), .base_i(base), .stretch_i(stretch));
    initial
        forever #25 core_clk_i = ~core_clk_i;
    function automatic logic [7:0] exp_byte(input int k);
        return base + 8'(k);
    endfunction
    task automatic bwr(input logic [1:0] a, input logic [7:0] d);
        @(posedge core_clk_i);
        addr <= a; wdata <= d; wr <= 1'b1;
        @(posedge core_clk_i);
        wr <= 1'b0;
    endtask
    task automatic brd(input logic [1:0] a, output logic [7:0] d);
        @(posedge core_clk_i);
        addr <= a; rd <= 1'b1;
        @(posedge core_clk_i);
        rd <= 1'b0;
        @(negedge core_clk_i);
        d = rdata;
    endtask
    task automatic chk(input logic [1:0] a, input logic [7:0] e);
        brd(a, v);
        `CHK(v, e)
    endtask
    // bounded poll of one control bit
    task automatic wait_ctl(input int b, input logic val);
        brd(CTL, v);
        for (int i = 0; i < 3000 && v[b] !== val; i++)
            brd(CTL, v);
        `CHK(v[b], val)
    endtask
    task automatic go(input logic [7:0] ctl, input logic [7:0] st);
        bwr(CTL, ctl);
        wait_ctl(7, 1'b1);
        chk(STS, st);
    endtask
    task automatic stop_test();
        $display("mismatches %0d tests_run %0d", mismatches, tests_run);
        if (mismatches == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial
    begin
        #(3000000);
        mismatches++;
        stop_test();
    end
    initial
    begin
        nb = $urandom(32'hfd6c);
        base = 8'($urandom);
        nb = $urandom_range(4, 1);
        repeat (16) @(posedge core_clk_i);
        reset_i <= 1'b0;
        chk(CTL, 8'h00);
        chk(STS, 8'hf8);
        chk(DAT, 8'hff);
        chk(2'h3, 8'h00);
        bwr(DAT, 8'h55);
        chk(CTL, 8'h08);
        chk(DAT, 8'hff);
        go(8'ha4, 8'h08);
        bwr(CTL, 8'h24);
        chk(STS, 8'h08);
        bwr(DAT, {DEV, 1'b1});
        go(8'h84, 8'h40);
        for (int k = 0; k < nb; k++)
        begin
            go((k < nb - 1) ? 8'hc4 : 8'h84, (k < nb - 1) ? 8'h50 : 8'h58);
            chk(DAT, exp_byte(k));
        end
        bwr(CTL, 8'h94);
        wait_ctl(4, 1'b0);
        chk(STS, 8'hf8);
        stretch <= 1'b1;
        go(8'ha4, 8'h08);
        bwr(DAT, {DEV ^ 7'h01, 1'b1});
        go(8'h84, 8'h48);
        go(8'hb4, 8'h08);
        brd(CTL, v);
        `CHK(v[4], 1'b0)
        bwr(DAT, {DEV, 1'b1});
        go(8'h84, 8'h40);
        `CHK(tx_mode, 1'b0)
        go(8'h84, 8'h58);
        chk(DAT, exp_byte(0));
        go(8'ha4, 8'h10);
        bwr(DAT, {DEV, 1'b0});
        go(8'h84, 8'h20);
        `CHK(tx_mode, 1'b1)
        bwr(CTL, 8'h94);
        wait_ctl(4, 1'b0);
        chk(STS, 8'hf8);
        stop_test();
    end
endmodule
